// ==== dv/isr_host_model.sv ====
// Host model: SPI master in mode 0, one 48 ns serial clock per bit.
// Drives on REF_CLK rising edges; answer bits are taken at each serial rise.
`timescale 1ns/1ps
module isr_host_model (
    input logic clk,
    input logic miso,
    output logic sclk,
    output logic cs_n,
    output logic mosi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Frame of n bits; excess bits go low, and idle MOSI inverts so it never looks valid
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
        r = 32'h0;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi <= (i < 32) ? w[31 - i] : 1'b0;
            repeat (6) @(posedge clk);
            sclk <= 1'b1;
            r = {r[30:0], miso};
            repeat (6) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (6) @(posedge clk);
    endtask
endmodule // isr_host_model

// ==== dv/isr_readout_sva.sv ====
// Checker for the SPI readout block: pin framing, alarm pin and bad-count answers.
// Bound to every readout instance; sees only its ports.
`timescale 1ns/1ps
module isr_readout_sva #(
    parameter int ALARM_ON_CYC = 20,
    parameter int ALARM_OFF_CYC = 100
) (
    input logic REF_CLK,
    input logic NRST,
    input logic PWR_DOWN,
    input logic SCLK,
    input logic CHIP_SELECT_N,
    input logic MISO,
    input logic MISO_OE,
    input logic SAFETY_ALARM,
    input logic ALARM_OUT_N
);
    logic [31:0] st_q;
    logic [31:0] sh_q;
    logic [5:0] n_q;
    logic sclk_q;
    logic cs_q;
    logic bad_q;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // Cycles since reset, plus a shadow of each frame's edges and answer bits
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st_q <= 32'h0;
            sh_q <= 32'h0;
            n_q <= 6'h0;
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            bad_q <= 1'b0;
        end else begin
            st_q <= (st_q == 32'hffffffff) ? st_q : st_q + 32'h1;
            sclk_q <= SCLK;
            cs_q <= CHIP_SELECT_N;
            if (!CHIP_SELECT_N && cs_q) begin
                n_q <= 6'h0;
            end else if (SCLK && !sclk_q && !CHIP_SELECT_N && n_q != 6'h3f) begin
                n_q <= n_q + 6'h1;
                sh_q <= {sh_q[30:0], MISO};
            end
            // Power down drops the pending answer, so forget the old count too
            if (PWR_DOWN) begin
                bad_q <= 1'b0;
            end else if (CHIP_SELECT_N && !cs_q) begin
                bad_q <= (n_q != 6'd32);
            end
        end
    end
    a_oe_in_frame: assert property (!CHIP_SELECT_N [*5] |-> MISO_OE)
        else $error("MISO_OE low inside a frame");
    a_oe_off_idle: assert property (CHIP_SELECT_N [*5] |-> !MISO_OE)
        else $error("MISO_OE high outside a frame");
    a_miso_hold_high: assert property ($rose(SCLK) && !CHIP_SELECT_N |-> $stable(MISO) [*5])
        else $error("MISO moved while SCLK high");
    a_alarm_early: assert property (st_q < ALARM_ON_CYC |-> ALARM_OUT_N)
        else $error("alarm pin low before self-test window");
    a_selftest_low: assert property (st_q >= ALARM_ON_CYC + 5 && st_q <= ALARM_OFF_CYC
        |-> !ALARM_OUT_N)
        else $error("alarm pin high inside self-test window");
    a_alarm_mirror: assert property ($rose(SAFETY_ALARM) |-> ##[1:2] !ALARM_OUT_N)
        else $error("alarm pin slow to follow alarm");
    a_alarm_holds: assert property (SAFETY_ALARM [*3] |-> !ALARM_OUT_N)
        else $error("alarm pin high during alarm");
    a_alarm_release: assert property (!SAFETY_ALARM [*3] ##0 (st_q > ALARM_OFF_CYC + 5)
        |-> ALARM_OUT_N)
        else $error("alarm pin low without alarm");
    a_count_error: assert property (CHIP_SELECT_N && !cs_q && bad_q && n_q == 6'd32
        |-> sh_q == 32'h00000903)
        else $error("bad edge count not answered with SPI error");
endmodule // isr_readout_sva

bind isr_readout isr_readout_sva #(
    .ALARM_ON_CYC(ALARM_ON_CYC),
    .ALARM_OFF_CYC(ALARM_OFF_CYC)
) u_sva (
    .REF_CLK(REF_CLK), .NRST(NRST), .PWR_DOWN(PWR_DOWN), .SCLK(SCLK),
    .CHIP_SELECT_N(CHIP_SELECT_N), .MISO(MISO), .MISO_OE(MISO_OE),
    .SAFETY_ALARM(SAFETY_ALARM), .ALARM_OUT_N(ALARM_OUT_N)
);

// ==== dv/isr_readout_tb_top.sv ====
// Bench: data reads, sync capture, keep-alive, error words, alarm pin.
// Drives the block through the host model; self-test counts are shortened.
`timescale 1ns/1ps
module isr_readout_tb_top;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic pwr_down = 1'b0;
    logic safety = 1'b0;
    logic [15:0] smp [0:8];
    logic [31:0] exp_q;
    logic [1:0] keep_alive_count = 2'h0;
    int err_total = 0;
    int samples_checked = 0;
    wire sclk, cs_n, mosi, miso, miso_oe, alarm_n;
    // Half period of 2 ns gives the 250 MHz reference
    always #2 ref_clk = ~ref_clk;
    isr_readout #(.ALARM_ON_CYC(20), .ALARM_OFF_CYC(100)) dut (
        .REF_CLK(ref_clk), .NRST(nrst), .PWR_DOWN(pwr_down), .SCLK(sclk),
        .CHIP_SELECT_N(cs_n), .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe),
        .SAFETY_ALARM(safety), .GYRO_X(smp[0]), .GYRO_Y(smp[1]), .GYRO_Z(smp[2]),
        .ACCEL_X(smp[3]), .ACCEL_Y(smp[4]), .ACCEL_Z(smp[5]), .TEMP1(smp[6]),
        .TEMP2(smp[7]), .TEMP_DIFF(smp[8]), .ALARM_OUT_N(alarm_n));
    isr_host_model host (.clk(ref_clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
    // x^4+1 from 0xa folds to the seed xor the seven nibbles
    function automatic logic [31:0] seal(input logic [27:0] b);
        logic [3:0] c;
        c = 4'ha;
        for (int j = 0; j < 7; j++) c = c ^ b[j*4 +: 4];
        return {b, c};
    endfunction
    function automatic logic [31:0] cmdw(input logic [2:0] m, input logic [3:0] s, input logic x);
        return seal({16'h0, m, 1'b0, s, x, 3'h0});
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask
    // Only full frames carry a whole answer worth comparing
    task automatic frame(input logic [31:0] w, input int n, input logic [31:0] nxt);
        logic [31:0] got;
        host.xfer(w, n, got);
        if (n == 32) check(got, exp_q);
        exp_q = nxt;
    endtask
    task automatic rd(input logic [3:0] s, input logic x, input logic [15:0] v, input logic [1:0] f);
        frame(cmdw(3'h5, s, x), 32, seal({v, f, 2'h2, s, x, 1'b0, keep_alive_count}));
        keep_alive_count = keep_alive_count + 2'h1;
    endtask
    task automatic set_gen(input logic [15:0] base);
        for (int i = 0; i < 9; i++) smp[i] <= base + 16'(i);
    endtask
    task automatic wrap_up();
        if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 9; i++) smp[i] = 16'h0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (60) @(posedge ref_clk);
        check({31'h0, alarm_n}, 32'h0);
        repeat (90) @(posedge ref_clk);
        check({31'h0, alarm_n}, 32'h1);
        exp_q = 32'h0;
        set_gen(16'h2a00);
        rd(4'hf, 1'b1, 16'haa55, 2'h2);
        // Live samples change after the capture, stored ones must still come back
        for (int i = 0; i < 9; i++) begin
            rd(4'(i < 6 ? 2 * i : i + 6), 1'b0, 16'h2a00 + 16'(i), 2'h2);
            if (i == 0) set_gen(16'h9c40);
        end
        rd(4'hf, 1'b1, 16'haa55, 2'h2);
        rd(4'h0, 1'b0, 16'h9c40, 2'h2);
        safety <= 1'b1;
        rd(4'h2, 1'b0, 16'h9c41, 2'h1);
        check({31'h0, alarm_n}, 32'h0);
        safety <= 1'b0;
        // New live values would show up only if an errored frame armed a capture
        set_gen(16'h5000);
        frame(cmdw(3'h5, 4'h0, 1'b0) ^ 32'h1, 32, 32'h00000903);
        frame(cmdw(3'h4, 4'h0, 1'b0), 32, 32'h00000a00);
        frame(cmdw(3'h5, 4'h1, 1'b0), 32, 32'h00000a00);
        frame(cmdw(3'h5, 4'h0, 1'b1), 31, 32'h00000903);
        rd(4'h4, 1'b0, 16'h9c42, 2'h2);
        frame(cmdw(3'h5, 4'h0, 1'b1), 33, 32'h00000903);
        rd(4'h6, 1'b0, 16'h9c43, 2'h2);
        rd(4'h8, 1'b0, 16'h9c44, 2'h2);
        pwr_down <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pwr_down <= 1'b0;
        exp_q = 32'h0;
        keep_alive_count = 2'h0;
        rd(4'hf, 1'b0, 16'haa55, 2'h2);
        rd(4'hf, 1'b0, 16'haa55, 2'h2);
        wrap_up();
    end
    // Watchdog well beyond the expected run of about 9300 cycles
    initial begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        wrap_up();
    end
endmodule // isr_readout_tb_top

// ==== verilog/isr_crc4.v ====
// 4-bit CRC over the upper 28 bits of a 32-bit SPI word.
// Pure combinational; the caller supplies bits 31..4, MSB first.
`timescale 1ns/1ps
`include "isr_defs.vh"

module isr_crc4 (
    input wire [`ISR_BODY_BITS-1:0] body,
    output reg [3:0] crc
);

    integer i;

    // Serial LFSR unrolled over the word, most significant bit first
    always @* begin
        crc = `ISR_CRC_INIT;
        for (i = `ISR_BODY_BITS - 1; i >= 0; i = i - 1) begin
            if (crc[3] ^ body[i]) begin
                crc = {crc[2:0], 1'b0} ^ `ISR_CRC_POLY;
            end else begin
                crc = {crc[2:0], 1'b0};
            end
        end
    end

endmodule // isr_crc4

// ==== verilog/isr_defs.vh ====
// Constants for the inertial sensor SPI data readout block.
// Assumes a 250 MHz reference clock and a 32-bit, MSB-first SPI frame.
`ifndef ISR_DEFS_VH
`define ISR_DEFS_VH

// Frame geometry
`define ISR_FRAME_BITS 6'd32
`define ISR_CNT_SAT 6'd33
`define ISR_CNT_W 6
`define ISR_BODY_BITS 28

// Command field positions
`define ISR_MODE_HI 15
`define ISR_MODE_LO 13
`define ISR_SEL_HI 11
`define ISR_SEL_LO 8
`define ISR_SYNC_BIT 7
`define ISR_CRC_HI 3
`define ISR_CRC_LO 0

// Command values
`define ISR_MODE_DATA 3'h5
`define ISR_SEL_TEMP2 4'hd
`define ISR_SEL_FIXED 4'hf
`define ISR_FIXED_VALUE 16'haa55
`define ISR_CMD_ZERO 16'h0000

// Response fields
`define ISR_FLAG_OK 2'h2
`define ISR_FLAG_ALARM 2'h1
`define ISR_RSP_MODE 2'h2
`define ISR_SPI_ERR_BODY 28'h0000090
`define ISR_UNREC_BODY 28'h00000a0
`define ISR_RESET_WORD 32'h00000000

// CRC x^4+1, seed 0xa
`define ISR_CRC_POLY 4'h1
`define ISR_CRC_INIT 4'ha

// Clock and start-up alarm window (times in ns)
`define ISR_CLK_PERIOD_NS 4
`define ISR_ALARM_ON_NS 11500000
`define ISR_ALARM_OFF_NS 75500000
`define ISR_ST_CNT_W 25

`endif

// ==== verilog/isr_readout.v ====
// SPI slave for the data monitor readout of a six-axis inertial sensor.
// Assumes SCLK, CHIP_SELECT_N and MOSI come from an external SPI master and
// that sample and safety inputs are produced on REF_CLK.
//
// Contract
// - A transaction is exactly 32 serial clocks while chip select is low.
// - MSB first; sample on rising serial clock, change on falling edge.
// - The answer to a command is shifted out in the following frame.
// - Bits 11..8 select the data type; odd codes other than 1101/1111 reserved.
// - Selected sample returned in bits 31..16 as 16-bit two's complement.
// - Bits 15..14 read 10 without alarm, 01 with any alarm.
// - Active-low alarm pin is low whenever the error flag is 01.
// - After reset the alarm pin is low from 11.5 ms to 75.5 ms.
// - Sync capture bit 0 suspends acquisition of new samples.
// - Chip select fall after a frame with sync bit 1 captures all types.
// - While suspended, stored samples are still returned on request.
// - Bits 5..4 carry a 2-bit keep-alive count, incremented per data read.
// - Keep-alive count ignores sync bit and is shared by all types.
// - Keep-alive count is cleared only by reset or power down.
// - Low four bits of each frame carry a CRC over the upper 28 bits; the all-zero word sent after reset or power down has 0 there.
// - CRC uses x^4+1, polynomial 0x1, initial value 0xA.
// - A communication error is reported in the next frame.
// - A frame that raises an error performs no action.
// - A pending error clears on reset, power down or next good frame.
// - Wrong clock count, bad CRC or failed decoding answer 0x00000903.
// - Fewer than 32 clocks: missing bits hold the last received level.
// - More than 32 clocks: excess bits are taken as low.
// - Well-formed undefined command answers 0x00000a00.
`timescale 1ns/1ps
`include "isr_defs.vh"

module isr_readout #(
    parameter ALARM_ON_CYC = `ISR_ALARM_ON_NS / `ISR_CLK_PERIOD_NS,
    parameter ALARM_OFF_CYC = `ISR_ALARM_OFF_NS / `ISR_CLK_PERIOD_NS
) (
    input wire REF_CLK,
    input wire NRST,
    input wire PWR_DOWN,
    input wire SCLK,
    input wire CHIP_SELECT_N,
    input wire MOSI,
    output reg MISO,
    output reg MISO_OE,
    input wire SAFETY_ALARM,
    input wire [15:0] GYRO_X,
    input wire [15:0] GYRO_Y,
    input wire [15:0] GYRO_Z,
    input wire [15:0] ACCEL_X,
    input wire [15:0] ACCEL_Y,
    input wire [15:0] ACCEL_Z,
    input wire [15:0] TEMP1,
    input wire [15:0] TEMP2,
    input wire [15:0] TEMP_DIFF,
    output reg ALARM_OUT_N
);

    // Select codes that name a stored data type
    function is_defined_sel;
        input [3:0] sel;
        begin
            is_defined_sel = ~sel[0] | (sel == `ISR_SEL_TEMP2) | (sel == `ISR_SEL_FIXED);
        end
    endfunction

    reg [2:0] sclk_sync_q;
    reg [2:0] cs_sync_q;
    reg [1:0] mosi_sync_q;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire cs_rise;
    wire cs_low;
    wire mosi_s;

    // Two-stage synchronisers; the third stage only feeds edge detection
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            sclk_sync_q <= 3'h0;
            cs_sync_q <= 3'h7;
            mosi_sync_q <= 2'h0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], SCLK};
            cs_sync_q <= {cs_sync_q[1:0], CHIP_SELECT_N};
            mosi_sync_q <= {mosi_sync_q[0], MOSI};
        end
    end

    assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
    assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
    assign cs_fall = ~cs_sync_q[1] & cs_sync_q[2];
    assign cs_rise = cs_sync_q[1] & ~cs_sync_q[2];
    assign cs_low = ~cs_sync_q[1];
    assign mosi_s = mosi_sync_q[1];

    reg [31:0] rx_q;
    reg [31:0] tx_q;
    reg [31:0] rsp_q;
    reg [`ISR_CNT_W-1:0] cnt_q;
    reg last_bit_q;
    reg sync_pend_q;
    reg [1:0] keep_alive_count_q;
    reg [`ISR_ST_CNT_W-1:0] st_cnt_q;
    reg st_alarm_q;
    reg alarm_q;

    // Start-up self-test window, counted once after reset
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st_cnt_q <= {`ISR_ST_CNT_W{1'b0}};
            st_alarm_q <= 1'b0;
        end else begin
            if (st_cnt_q != ALARM_OFF_CYC[`ISR_ST_CNT_W-1:0]) begin
                st_cnt_q <= st_cnt_q + 1'b1;
            end
            st_alarm_q <= (st_cnt_q >= ALARM_ON_CYC[`ISR_ST_CNT_W-1:0]) &&
                          (st_cnt_q < ALARM_OFF_CYC[`ISR_ST_CNT_W-1:0]);
        end
    end

    // Common alarm: safety mechanisms or the self-test window
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            alarm_q <= 1'b0;
            ALARM_OUT_N <= 1'b1;
        end else begin
            alarm_q <= SAFETY_ALARM | st_alarm_q;
            ALARM_OUT_N <= ~alarm_q;
        end
    end

    // Completed receive word, padded for a short frame
    reg [31:0] rx_full;
    reg [5:0] fill;
    integer j;

    always @* begin
        rx_full = rx_q;
        fill = 6'h0;
        if (cnt_q < `ISR_FRAME_BITS) begin
            fill = `ISR_FRAME_BITS - cnt_q;
            for (j = 0; j < 32; j = j + 1) begin
                if (j < fill) begin
                    rx_full[j] = last_bit_q;
                end else begin
                    rx_full[j] = rx_q[j - fill];
                end
            end
        end
    end

    wire [3:0] rx_crc;
    wire [3:0] sel = rx_full[`ISR_SEL_HI:`ISR_SEL_LO];
    wire sync_bit = rx_full[`ISR_SYNC_BIT];
    wire frame_ok;
    wire layout_ok;
    wire cmd_ok;

    isr_crc4 u_rx_crc (
        .body(rx_full[31:4]),
        .crc(rx_crc)
    );

    // Fixed-zero fields must hold; the mode and select must be known
    assign frame_ok = (cnt_q == `ISR_FRAME_BITS) &&
                      (rx_crc == rx_full[`ISR_CRC_HI:`ISR_CRC_LO]);
    assign layout_ok = (rx_full[31:16] == `ISR_CMD_ZERO) && !rx_full[12] &&
                       (rx_full[6:4] == 3'h0);
    assign cmd_ok = (rx_full[`ISR_MODE_HI:`ISR_MODE_LO] == `ISR_MODE_DATA) &&
                    is_defined_sel(sel);

    // Result registers, one per select code; only defined codes are ever loaded
    wire [16*16-1:0] live;
    assign live = {`ISR_FIXED_VALUE, TEMP_DIFF, TEMP2, TEMP1,
                   16'h0000, ACCEL_Z, 16'h0000, ACCEL_Y,
                   16'h0000, ACCEL_X, 16'h0000, GYRO_Z,
                   16'h0000, GYRO_Y, 16'h0000, GYRO_X};

    reg [15:0] result_q [0:15];
    genvar g;

    generate
        for (g = 0; g < 16; g = g + 1) begin : g_result
            // All types latch together only on the armed chip-select fall
            always @(posedge REF_CLK or negedge NRST) begin
                if (!NRST) begin
                    result_q[g] <= 16'h0000;
                end else if (cs_fall && sync_pend_q && is_defined_sel(g)) begin
                    result_q[g] <= live[g*16 +: 16];
                end
            end
        end
    endgenerate

    // Next response word, before its CRC
    reg [27:0] rsp_body;
    wire [3:0] rsp_crc;

    always @* begin
        if (!frame_ok || !layout_ok) begin
            rsp_body = `ISR_SPI_ERR_BODY;
        end else if (!cmd_ok) begin
            rsp_body = `ISR_UNREC_BODY;
        end else begin
            // The fixed word never waits for a capture, so it is valid from reset
            rsp_body = {((sel == `ISR_SEL_FIXED) ? `ISR_FIXED_VALUE : result_q[sel]),
                        (alarm_q ? `ISR_FLAG_ALARM : `ISR_FLAG_OK),
                        `ISR_RSP_MODE, sel, sync_bit, 1'b0, keep_alive_count_q};
        end
    end

    isr_crc4 u_tx_crc (
        .body(rsp_body),
        .crc(rsp_crc)
    );

    // Serial shift engine on the reference clock
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_q <= 32'h0;
            tx_q <= `ISR_RESET_WORD;
            cnt_q <= {`ISR_CNT_W{1'b0}};
            last_bit_q <= 1'b0;
            MISO <= 1'b0;
            MISO_OE <= 1'b0;
        end else begin
            MISO_OE <= cs_low;
            if (cs_fall) begin
                tx_q <= rsp_q;
                MISO <= rsp_q[31];
                cnt_q <= {`ISR_CNT_W{1'b0}};
                rx_q <= 32'h0;
            end else if (cs_low && sclk_rise) begin
                if (cnt_q < `ISR_FRAME_BITS) begin
                    rx_q <= {rx_q[30:0], mosi_s};
                    last_bit_q <= mosi_s;
                end else begin
                    rx_q <= {rx_q[30:0], 1'b0};
                end
                if (cnt_q != `ISR_CNT_SAT) begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end else if (cs_low && sclk_fall) begin
                tx_q <= {tx_q[30:0], 1'b0};
                MISO <= tx_q[30];
            end
        end
    end

    wire data_read = frame_ok && layout_ok && cmd_ok;

    // Frame completion: build the answer and apply the command's effects
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rsp_q <= `ISR_RESET_WORD;
            sync_pend_q <= 1'b0;
            keep_alive_count_q <= 2'h0;
        end else if (PWR_DOWN) begin
            rsp_q <= `ISR_RESET_WORD;
            sync_pend_q <= 1'b0;
            keep_alive_count_q <= 2'h0;
        end else begin
            if (cs_fall) begin
                sync_pend_q <= 1'b0;
            end
            if (cs_rise) begin
                rsp_q <= {rsp_body, rsp_crc};
                if (data_read) begin
                    sync_pend_q <= sync_bit;
                    keep_alive_count_q <= keep_alive_count_q + 1'b1;
                end else begin
                    sync_pend_q <= 1'b0;
                end
            end
        end
    end

endmodule // isr_readout
